/* File: hw/efp_pkg.sv */
// Purpose: shared constants for encoder feedback and pwm setup
// Assumes: 10 MHz system clock, apb register access
// Notes: times kept in 10 ms ticks, switching frequency in 10 Hz units
package efp_pkg;
    // clock and tick timing
    localparam int CLK_HZ = 10000000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int COMM_LOSS_MS = 2000;
    localparam int COMM_LOSS_TICKS = COMM_LOSS_MS / TICK_MS;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LINES = 8'h04;
    localparam logic [7:0] OFS_POS = 8'h08;
    localparam logic [7:0] OFS_POS16 = 8'h0C;
    localparam logic [7:0] OFS_SPEED = 8'h10;
    localparam logic [7:0] OFS_DELAY = 8'h14;
    localparam logic [7:0] OFS_BAND = 8'h18;
    localparam logic [7:0] OFS_FSW = 8'h1C;
    localparam logic [7:0] OFS_MAXDEV = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    // control field positions
    localparam int CTRL_FB = 0;
    localparam int CTRL_PH = 1;
    localparam int CTRL_SND = 2;
    localparam int CTRL_MODE = 5;
    localparam int CTRL_RND = 6;
    // status field positions
    localparam int ST_BOARD = 0;
    localparam int ST_COMM = 1;
    localparam int ST_PULSE = 2;
    localparam int ST_DEV = 3;
    // setting values, limits and resets
    localparam logic [2:0] SND_FIXED = 3'h1;
    localparam logic [2:0] SND_ADV = 3'h4;
    localparam logic [15:0] LINES_MIN = 16'h0005;
    localparam logic [15:0] LINES_MAX = 16'h4000;
    localparam logic [15:0] LINES_RST = 16'h0400;
    localparam logic [15:0] FSW_FIXED = 16'h012C;
    localparam logic [15:0] FSW_MIN = 16'h0096;
    localparam logic [15:0] FSW_MAX = 16'h0258;
    localparam logic [15:0] FSW_MAX_HI = 16'h0320;
    localparam logic [15:0] FSW_RST = 16'h012C;
    localparam logic [15:0] DELAY_MAX = 16'h03E8;
    localparam logic [15:0] BAND_MAX = 16'h0190;
    localparam logic [15:0] BAND_RST = 16'h000A;
    localparam logic [3:0] DEV_TRIP_CODE = 4'h2;
    // rpm per window edge = 60 s / (4 edges * window) / lines
    localparam logic [15:0] RPM_SCALE = 16'h05DC;
endpackage : efp_pkg

/* File: hw/efp_top.sv */
// Purpose: encoder decode, speed, supervision and pwm settings
// Assumes: apb slave with zero wait states, one clock
// Notes: encoder pins are synchronised before any decoding
//
// Overview of operation
// RULE1: speed feedback passes to control only while feedback enable is one.
// RULE2: encoder line count 5..16384, default 1024, scales measured speed.
// RULE3: position count is signed 32-bit, reset to zero.
// RULE4: position counts up for positive and down for negative rotation.
// RULE5: host presets position as a 16-bit or 32-bit value.
// RULE6: every edge of both channels counts, four per line.
// RULE7: speed only trustworthy within 16-bit span; no saturation applied.
// RULE8: encoder enabled but no board after power-up raises encoder trip.
// RULE9: board link lost over 2 seconds raises encoder trip.
// RULE10: no pulses for fault delay under torque or current limit trips.
// RULE11: speed outside band for the fault delay raises deviation trip.
// RULE12: deviation trip reports code two.
// RULE13: fault delay 0.01..10.00 s, zero disables, zero by default.
// RULE14: band bounds speed minus ramp, 0..400 percent, default 10.
// RULE15: longest out-of-band time recorded to 10 s, cleared by zero.
// RULE16: longest out-of-band time comes up zero after power-up.
// RULE17: phase order zero gives U V W, one gives U W V.
// RULE18: sound one forces 3 kHz, four applies advanced settings.
// RULE19: switching reference 1.50..6.00 kHz, 8 kHz above 400 Hz motors.
// RULE20: overtemperature lowers switching frequency, never below 1.5 kHz.
// RULE21: sine filter mode fixes frequency, no thermal reduction.
// RULE22: random modulation varies frequency within one eighth.
// RULE23: direction from channel phase; swapping channels flips sign.
// RULE24: inputs synchronised; simultaneous change of both ignored.
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module efp_top
    import efp_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // encoder board pins
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic board_present,
    input wire logic board_link_ok,
    // drive state from control logic
    input wire logic torque_limit_state,
    input wire logic current_limit_state,
    input wire logic switch_overtemp,
    input wire logic motor_freq_above_400,
    input wire logic signed [31:0] ramp_rpm,
    // modulator phase inputs and motor outputs
    input wire logic mod_u,
    input wire logic mod_v,
    input wire logic mod_w,
    output logic drive_u,
    output logic drive_v,
    output logic drive_w,
    // results to control
    output logic signed [31:0] speed_feedback,
    output logic [15:0] fsw_actual,
    output logic encoder_trip,
    output logic deviation_trip,
    output logic [3:0] deviation_trip_code
);
    typedef enum logic [1:0] {EFP_IDLE, EFP_DIV, EFP_DONE} efp_div_e;

    logic [6:0] ctrl;
    logic [15:0] lines, delay, band, fsw_ref, max_deviation_time;
    logic [3:0] status;
    logic signed [31:0] position, speed, win_cnt;
    logic [2:0] sa, sb, sp, sl;
    logic ca, cb, step, dir_up;
    logic [31:0] tick_cnt;
    logic tick;
    logic wr, rd;
    logic [15:0] nopulse_cnt, dev_cnt, comm_cnt, fsw_therm;
    logic out_band, board_seen;
    logic [63:0] rem;
    logic [31:0] quo;
    logic [5:0] div_n;
    logic div_neg;
    efp_div_e div_st;
    logic [15:0] lfsr;
    logic [15:0] fsw_cap, rnd_span, next_fsw;
    logic [16:0] rnd_off;
    logic [32:0] diff_mag, ramp_mag;

    // apb decode, no wait states
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    assign fsw_cap = motor_freq_above_400 ? FSW_MAX_HI : FSW_MAX;

    // pin synchronisers, stage 0 read only by stage 1
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sa <= 3'h0;
            sb <= 3'h0;
            sp <= 3'h0;
            sl <= 3'h0;
        end else begin
            sa <= {sa[1:0], enc_a}; // RULE24
            sb <= {sb[1:0], enc_b}; // RULE24
            sp <= {sp[1:0], board_present};
            sl <= {sl[1:0], board_link_ok};
        end
    end

    // edge detect on synchronised channels
    assign ca = sa[1] ^ sa[2];
    assign cb = sb[1] ^ sb[2];
    assign step = ca ^ cb; // RULE6 RULE24
    assign dir_up = sa[1] ^ sb[2]; // RULE23

    // 10 ms tick divider
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            tick_cnt <= 32'h0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0
                : tick_cnt + 32'h1;
        end
    end

    // position counter with host preset
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            position <= 32'sh0; // RULE3
        end else if (wr && paddr == OFS_POS) begin
            position <= pwdata; // RULE5
        end else if (wr && paddr == OFS_POS16) begin
            position <= {{16{pwdata[15]}}, pwdata[15:0]}; // RULE5
        end else if (step) begin
            position <= dir_up ? position + 32'sh1
                : position - 32'sh1; // RULE4
        end
    end

    // edges per window, then rpm = edges * scale / lines
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            win_cnt <= 32'sh0;
            div_st <= EFP_IDLE;
            rem <= 64'h0;
            quo <= 32'h0;
            div_n <= 6'h0;
            div_neg <= 1'b0;
            speed <= 32'sh0;
        end else begin
            if (tick) begin
                win_cnt <= step ? (dir_up ? 32'sh1 : -32'sh1) : 32'sh0;
            end else if (step) begin
                win_cnt <= dir_up ? win_cnt + 32'sh1 : win_cnt - 32'sh1;
            end
            case (div_st)
                EFP_IDLE: begin
                    if (tick) begin
                        div_neg <= win_cnt[31];
                        rem <= {32'h0, 32'(($unsigned(win_cnt[31]
                            ? -win_cnt : win_cnt)) * RPM_SCALE)};
                        quo <= 32'h0;
                        div_n <= 6'h0;
                        div_st <= EFP_DIV;
                    end
                end
                EFP_DIV: begin
                    // restoring divide by line count, one bit per cycle
                    if (rem[62:31] >= {16'h0, lines}) begin // RULE2
                        rem <= {rem[62:31] - {16'h0, lines}, rem[30:0],
                            1'b0};
                        quo <= {quo[30:0], 1'b1};
                    end else begin
                        rem <= {rem[62:0], 1'b0};
                        quo <= {quo[30:0], 1'b0};
                    end
                    div_n <= div_n + 6'h1;
                    if (div_n == 6'd31) begin
                        div_st <= EFP_DONE;
                    end
                end
                EFP_DONE: begin
                    speed <= div_neg ? -$signed(quo) : $signed(quo); // RULE7
                    div_st <= EFP_IDLE;
                end
                default: div_st <= EFP_IDLE;
            endcase
        end
    end

    // speed to control only when feedback enabled
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            speed_feedback <= 32'sh0;
        end else begin
            speed_feedback <= ctrl[CTRL_FB] ? speed : 32'sh0; // RULE1
        end
    end

    // settings registers, out-of-range writes refused
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctrl <= {2'h0, SND_FIXED, 2'h0}; // RULE1 RULE18
            lines <= LINES_RST; // RULE2
            delay <= 16'h0; // RULE13
            band <= BAND_RST; // RULE14
            fsw_ref <= FSW_RST;
        end else if (wr) begin
            case (paddr)
                OFS_CTRL: ctrl <= pwdata[6:0];
                OFS_LINES: begin
                    if (pwdata[15:0] >= LINES_MIN
                        && pwdata[15:0] <= LINES_MAX
                        && pwdata[31:16] == 16'h0) begin
                        lines <= pwdata[15:0]; // RULE2
                    end
                end
                OFS_DELAY: begin
                    if (pwdata[15:0] <= DELAY_MAX
                        && pwdata[31:16] == 16'h0) begin
                        delay <= pwdata[15:0]; // RULE13
                    end
                end
                OFS_BAND: begin
                    if (pwdata[15:0] <= BAND_MAX
                        && pwdata[31:16] == 16'h0) begin
                        band <= pwdata[15:0]; // RULE14
                    end
                end
                OFS_FSW: begin
                    if (pwdata[15:0] >= FSW_MIN && pwdata[15:0] <= fsw_cap
                        && pwdata[31:16] == 16'h0) begin
                        fsw_ref <= pwdata[15:0]; // RULE19
                    end
                end
                default: ;
            endcase
        end
    end

    // error answer for refused or unmapped accesses
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable && pwrite) begin
            case (paddr)
                OFS_CTRL, OFS_POS, OFS_POS16, OFS_STATUS: pslverr = 1'b0;
                OFS_LINES: pslverr = pwdata < 32'(LINES_MIN)
                    || pwdata > 32'(LINES_MAX);
                OFS_DELAY: pslverr = pwdata > 32'(DELAY_MAX);
                OFS_BAND: pslverr = pwdata > 32'(BAND_MAX);
                OFS_FSW: pslverr = pwdata < 32'(FSW_MIN)
                    || pwdata > 32'(fsw_cap);
                OFS_MAXDEV: pslverr = pwdata != 32'h0;
                default: pslverr = 1'b1;
            endcase
        end else if (psel && penable) begin
            pslverr = paddr > OFS_STATUS || paddr[1:0] != 2'h0;
        end
    end

    // read data latched in setup cycle
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            prdata <= 32'h0;
        end else if (rd) begin
            case (paddr)
                OFS_CTRL: prdata <= {25'h0, ctrl};
                OFS_LINES: prdata <= {16'h0, lines};
                OFS_POS: prdata <= position;
                OFS_POS16: prdata <= {{16{position[15]}}, position[15:0]};
                OFS_SPEED: prdata <= speed; // RULE7
                OFS_DELAY: prdata <= {16'h0, delay};
                OFS_BAND: prdata <= {16'h0, band};
                OFS_FSW: prdata <= {16'h0, fsw_ref};
                OFS_MAXDEV: prdata <= {16'h0, max_deviation_time};
                OFS_STATUS: prdata <= {fsw_actual, 8'h0,
                    deviation_trip_code, status};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // deviation band check: |speed - ramp| * 100 > band * |ramp|
    always_comb begin
        diff_mag = 33'(speed) - 33'(ramp_rpm);
        if (diff_mag[32]) begin
            diff_mag = -diff_mag;
        end
        ramp_mag = ramp_rpm[31] ? -33'(ramp_rpm) : 33'(ramp_rpm);
        out_band = 48'(diff_mag) * 48'd100
            > 48'(ramp_mag) * 48'(band); // RULE14
    end

    // supervision timers in ticks
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            nopulse_cnt <= 16'h0;
            dev_cnt <= 16'h0;
            comm_cnt <= 16'h0;
            max_deviation_time <= 16'h0; // RULE16
        end else begin
            if (step || !(torque_limit_state || current_limit_state)) begin
                nopulse_cnt <= 16'h0;
            end else if (tick && nopulse_cnt != DELAY_MAX) begin
                nopulse_cnt <= nopulse_cnt + 16'h1;
            end
            if (!out_band) begin
                dev_cnt <= 16'h0;
            end else if (tick && dev_cnt != DELAY_MAX) begin
                dev_cnt <= dev_cnt + 16'h1; // RULE11
            end
            if (sl[2]) begin
                comm_cnt <= 16'h0;
            end else if (tick && comm_cnt <= 16'(COMM_LOSS_TICKS)) begin
                comm_cnt <= comm_cnt + 16'h1; // RULE9
            end
            // growth wins over a host clear in the same cycle
            if (dev_cnt > max_deviation_time) begin
                max_deviation_time <= dev_cnt; // RULE15
            end else if (wr && paddr == OFS_MAXDEV && pwdata == 32'h0) begin
                max_deviation_time <= 16'h0; // RULE15
            end
        end
    end

    // sticky trips, write one to clear, set wins
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            status <= 4'h0;
            board_seen <= 1'b0;
        end else begin
            board_seen <= board_seen | tick;
            for (int i = 0; i < 4; i++) begin
                if (wr && paddr == OFS_STATUS && pwdata[i]) begin
                    status[i] <= 1'b0;
                end
            end
            if (board_seen && ctrl[CTRL_FB] && !sp[2]) begin
                status[ST_BOARD] <= 1'b1; // RULE8
            end
            if (comm_cnt > 16'(COMM_LOSS_TICKS)) begin
                status[ST_COMM] <= 1'b1; // RULE9
            end
            if (delay != 16'h0 && nopulse_cnt >= delay) begin
                status[ST_PULSE] <= 1'b1; // RULE10 RULE13
            end
            if (delay != 16'h0 && dev_cnt >= delay) begin
                status[ST_DEV] <= 1'b1; // RULE11 RULE13
            end
        end
    end

    assign encoder_trip = |status[ST_PULSE:ST_BOARD];
    assign deviation_trip = status[ST_DEV];
    assign deviation_trip_code = status[ST_DEV] ? DEV_TRIP_CODE
        : 4'h0; // RULE12

    // thermal reduction, stepping 10 Hz per tick
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            fsw_therm <= FSW_RST;
        end else if (ctrl[CTRL_MODE] || fsw_therm > fsw_ref) begin
            fsw_therm <= fsw_ref; // RULE21
        end else if (tick) begin
            if (switch_overtemp && fsw_therm > FSW_MIN) begin
                fsw_therm <= fsw_therm - 16'h1; // RULE20
            end else if (!switch_overtemp && fsw_therm < fsw_ref) begin
                fsw_therm <= fsw_therm + 16'h1;
            end
        end
    end

    // random offset in [-fsw_therm/8, +fsw_therm/8)
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            lfsr <= 16'hACE1;
        end else if (tick) begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
    end
    assign rnd_span = fsw_therm >> 3; // RULE22
    assign rnd_off = 17'((24'(lfsr[7:0]) * 24'(rnd_span)) >> 7);

    // selected switching frequency
    always_comb begin
        next_fsw = FSW_FIXED; // RULE18
        if (ctrl[CTRL_SND +: 3] == SND_ADV) begin
            next_fsw = fsw_therm; // RULE18
            if (ctrl[CTRL_RND] && !ctrl[CTRL_MODE]) begin // RULE21
                next_fsw = 16'(17'(fsw_therm) + rnd_off
                    - 17'(rnd_span)); // RULE22
            end
        end
    end

    // registered outputs to modulator
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            fsw_actual <= FSW_FIXED;
            drive_u <= 1'b0;
            drive_v <= 1'b0;
            drive_w <= 1'b0;
        end else begin
            fsw_actual <= next_fsw;
            drive_u <= mod_u;
            drive_v <= ctrl[CTRL_PH] ? mod_w : mod_v; // RULE17
            drive_w <= ctrl[CTRL_PH] ? mod_v : mod_w; // RULE17
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    fb_gate_a: assert property (!ctrl[CTRL_FB] |=> speed_feedback == 0)
        else $error("feedback used while disabled"); // RULE1
    pos_up_a: assert property (step && dir_up && !wr |=>
        position == $past(position) + 1)
        else $error("position did not count up"); // RULE4
    pos_pre_a: assert property (wr && paddr == OFS_POS16 |=>
        position == {{16{$past(pwdata[15])}}, $past(pwdata[15:0])})
        else $error("short preset wrong"); // RULE5
    both_edge_a: assert property (ca && cb && !wr |=> $stable(position))
        else $error("double change counted"); // RULE24
    dev_code_a: assert property (deviation_trip |-> deviation_trip_code == 2)
        else $error("wrong deviation code"); // RULE12
    delay_off_a: assert property (delay == 0 && $past(delay) == 0
        && !$past(status[ST_DEV]) |-> !$rose(status[ST_DEV]))
        else $error("trip with supervision off"); // RULE13
    phase_rev_a: assert property (ctrl[CTRL_PH] && $stable(ctrl) |=>
        drive_v == $past(mod_w) && drive_w == $past(mod_v))
        else $error("phase order wrong"); // RULE17
    fixed_fsw_a: assert property (ctrl[CTRL_SND +: 3] == SND_FIXED |=>
        fsw_actual == FSW_FIXED)
        else $error("fixed sound not 3 kHz"); // RULE18
    therm_min_a: assert property (fsw_therm >= FSW_MIN
        || fsw_therm == fsw_ref)
        else $error("thermal floor broken"); // RULE20
    max_keep_a: assert property (dev_cnt > max_deviation_time |=>
        max_deviation_time >= $past(dev_cnt))
        else $error("max deviation not recorded"); // RULE15
endmodule : efp_top

/* File: tb/efp_enc_model.sv */
// Purpose: quadrature encoder on the option board
// Assumes: one edge per go request, spaced wide enough for the synchroniser
// Notes: a jump request changes both channels at once
`timescale 1ns/1ns
module efp_enc_model (
    // clock
    input wire logic sys_clk,
    // step request
    input wire logic go,
    input wire logic dir,
    input wire logic jump,
    // quadrature channels
    output logic enc_a,
    output logic enc_b
);
    logic [1:0] ph = 2'h0;
    // one edge per request, both channels at once on jump, up moves a before b
    always_ff @(posedge sys_clk) begin
        if (go) begin
            ph <= jump ? ph + 2'h2 : dir ? ph + 2'h1 : ph - 2'h1;
        end
    end
    // gray outputs: 00 10 11 01 going up
    assign enc_a = ph[1] ^ ph[0];
    assign enc_b = ph[1];
endmodule : efp_enc_model

/* File: tb/encoder_feedback_and_pwm_setup_test.sv */
// Purpose: self-checking bench for efp_top
// Assumes: short tick parameter, apb master from the bench
// Notes: random steps and phases from a fixed-seed xorshift
`timescale 1ns/1ns
module encoder_feedback_and_pwm_setup_test;
    import efp_pkg::*;
    localparam int TK = 20;
    logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, enc_a, enc_b, go = 1'b0;
    logic dir = 1'b0, board_present = 1'b1, board_link_ok = 1'b1, jump = 1'b0;
    logic torque_limit_state = 1'b0, current_limit_state = 1'b0;
    logic switch_overtemp = 1'b0, motor_freq_above_400 = 1'b0;
    logic mod_u = 1'b0, mod_v = 1'b0, mod_w = 1'b0;
    logic drive_u, drive_v, drive_w, encoder_trip, deviation_trip, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat, n, m, r;
    logic signed [31:0] ramp_rpm = 32'sh0, speed_feedback;
    logic [15:0] fsw_actual;
    logic [3:0] deviation_trip_code;
    logic [31:0] seed = 32'h5DF40B6E;
    logic [7:0] ra [6] = '{OFS_LINES, OFS_LINES, OFS_DELAY, OFS_BAND,
        OFS_FSW, OFS_FSW};
    logic [15:0] rv [6] = '{16'h0004, 16'h4001, 16'h03E9, 16'h0191,
        16'h0095, 16'h0259};
    int bad_count = 0, compares = 0;
    efp_top #(.TICK_CYCLES(TK)) u_efp_top (.sys_clk(sys_clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
        .board_present(board_present), .board_link_ok(board_link_ok),
        .torque_limit_state(torque_limit_state),
        .current_limit_state(current_limit_state),
        .switch_overtemp(switch_overtemp),
        .motor_freq_above_400(motor_freq_above_400), .ramp_rpm(ramp_rpm),
        .mod_u(mod_u), .mod_v(mod_v), .mod_w(mod_w), .drive_u(drive_u),
        .drive_v(drive_v), .drive_w(drive_w),
        .speed_feedback(speed_feedback), .fsw_actual(fsw_actual),
        .encoder_trip(encoder_trip), .deviation_trip(deviation_trip),
        .deviation_trip_code(deviation_trip_code));
    efp_enc_model u_efp_enc_model (.sys_clk(sys_clk), .go(go), .dir(dir),
        .jump(jump), .enc_a(enc_a), .enc_b(enc_b));
    // 100 ns clock
    always #50 sys_clk = ~sys_clk;
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic finish_test();
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            $display("wrong value %s exp %h got %h", nm, e, g);
            bad_count++;
        end
    endtask : chk
    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) begin
            bad_count++;
            finish_test();
        end
        rdat = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), rdat, e);
    endtask : rchk
    task automatic wchk(input logic [7:0] a, input [31:0] d, input e);
        apb(1'b1, a, d);
        chk($sformatf("err %h", a), er, e);
    endtask : wchk
    task automatic step(input logic d, input logic [31:0] k);
        repeat (k) begin
            @(posedge sys_clk);
            go <= 1'b1;
            dir <= d;
            @(posedge sys_clk);
            go <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
    endtask : step
    task automatic await(ref logic s, input int k);
        for (int i = 0; i < k && s !== 1'b1; i++) @(posedge sys_clk);
        if (s !== 1'b1) begin
            bad_count++;
            finish_test();
        end
    endtask : await
    task automatic wt(input int t);
        repeat (t * TK) @(posedge sys_clk);
    endtask : wt
    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        rchk(OFS_CTRL, 32'h4);
        rchk(OFS_LINES, 32'h400);
        rchk(OFS_POS, 32'h0);
        rchk(OFS_DELAY, 32'h0);
        rchk(OFS_BAND, 32'hA);
        rchk(OFS_FSW, 32'h12C);
        rchk(OFS_MAXDEV, 32'h0);
        chk("fsw", fsw_actual, 32'h12C);
        for (int i = 0; i < 6; i++) wchk(ra[i], rv[i], 1'b1);
        wchk(OFS_FSW, 32'h320, 1'b1);
        motor_freq_above_400 <= 1'b1;
        wchk(OFS_FSW, 32'h320, 1'b0);
        wchk(OFS_MAXDEV, 32'h1, 1'b1);
        wchk(8'h28, 32'h1, 1'b1);
        rchk(8'h28, 32'h0);
        wchk(OFS_LINES, 32'h4000, 1'b0);
        rchk(OFS_LINES, 32'h4000);
        n = xs() % 32'd30 + 32'd1;
        m = xs() % 32'd30 + 32'd1;
        step(1'b1, n);
        rchk(OFS_POS, n);
        chk("speed", speed_feedback, 32'h0);
        step(1'b0, m);
        rchk(OFS_POS, n - m);
        jump <= 1'b1;
        step(1'b1, 32'd1);
        jump <= 1'b0;
        rchk(OFS_POS, n - m);
        wchk(OFS_POS16, 32'h8000, 1'b0);
        step(1'b0, 32'd1);
        rchk(OFS_POS, 32'hFFFF7FFF);
        wchk(OFS_POS, 32'h7FFFFFFF, 1'b0);
        step(1'b1, 32'd1);
        rchk(OFS_POS, 32'h80000000);
        wchk(OFS_LINES, 32'h5, 1'b0);
        wchk(OFS_CTRL, 32'h5, 1'b0);
        step(1'b1, 32'd16);
        // three or four edges per window at this step rate
        chk("speed", speed_feedback * 32'h5 / RPM_SCALE / 32'h3,
            32'h1);
        // phase order both ways with random modulator phases
        for (int p = 0; p < 2; p++) begin
            wchk(OFS_CTRL, (p << CTRL_PH) | 32'h4, 1'b0);
            repeat (8) begin
                r = xs();
                @(posedge sys_clk);
                {mod_u, mod_v, mod_w} <= r[2:0];
                @(posedge sys_clk);
                @(negedge sys_clk);
                chk("drv", {drive_u, drive_v, drive_w},
                    p ? {r[2], r[0], r[1]} : r[2:0]);
            end
        end
        wchk(OFS_FSW, 32'h96, 1'b0);
        wchk(OFS_CTRL, 32'h10, 1'b0);
        wt(5);
        chk("fsw adv", fsw_actual, 32'h96);
        wchk(OFS_CTRL, 32'h4, 1'b0);
        wt(5);
        chk("fsw fix", fsw_actual, 32'h12C);
        wchk(OFS_FSW, 32'hC8, 1'b0);
        wchk(OFS_CTRL, 32'h10, 1'b0);
        switch_overtemp <= 1'b1;
        wt(20);
        chk("fsw hot", fsw_actual, 32'h96);
        wchk(OFS_CTRL, 32'h30, 1'b0);
        wt(5);
        chk("fsw sine", fsw_actual, 32'hC8);
        switch_overtemp <= 1'b0;
        wchk(OFS_FSW, 32'h190, 1'b0);
        wchk(OFS_CTRL, 32'h50, 1'b0);
        r = 32'h0;
        repeat (8) begin
            wt(1);
            chk("fsw rnd", fsw_actual >= 16'd350 && fsw_actual <= 16'd450,
                32'h1);
            if (fsw_actual != 16'h190) r = 32'h1;
        end
        chk("fsw var", r, 32'h1);
        wchk(OFS_DELAY, 32'h3, 1'b0);
        ramp_rpm <= 32'sd1000;
        await(deviation_trip, 20 * TK);
        chk("code", deviation_trip_code, 32'h2);
        apb(1'b0, OFS_MAXDEV, 32'h0);
        chk("maxdev", rdat >= 32'd3, 32'h1);
        ramp_rpm <= 32'sd0;
        wt(2);
        wchk(OFS_MAXDEV, 32'h0, 1'b0);
        rchk(OFS_MAXDEV, 32'h0);
        torque_limit_state <= 1'b1;
        await(encoder_trip, 20 * TK);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("pulse", rdat[ST_PULSE], 32'h1);
        torque_limit_state <= 1'b0;
        wchk(OFS_DELAY, 32'h0, 1'b0);
        wchk(OFS_STATUS, 32'hF, 1'b0);
        @(posedge sys_clk);
        chk("trips", {encoder_trip, deviation_trip}, 32'h0);
        board_link_ok <= 1'b0;
        wt(150);
        chk("link early", encoder_trip, 32'h0);
        await(encoder_trip, 100 * TK);
        finish_test();
    end
endmodule : encoder_feedback_and_pwm_setup_test
